// ---- hw/vm_monitor.sv ----
// How it works
// RL1 - Separate high and low monitor per regulator
// RL2 - Low threshold code picks 95/93/91/89 percent
// RL3 - High threshold code picks 105/107/109/111 percent
// RL4 - Low debounce code picks 5/15/30/40 us
// RL5 - Low debounce field resets to 10
// RL6 - Shared high debounce picks 30/50/80/125 us
// RL7 - High debounce field resets to 00
// RL8 - Monitor enable one runs both monitors
// RL9 - Monitor enable zero stops the monitor
// RL10 - All monitor enables come up as one
// RL11 - Secure mode: only secure writes change enables
// RL12 - Newly enabled regulator masked until in regulation
// RL13 - Disabling a monitor clears its status
// RL14 - Debounce timed by 100 kHz logic clock
// RL15 - Status sets after continuous fault for debounce
// RL16 - Status clears when comparator returns normal
//
// The implementer's own choices: the address map and the AHB-Lite slave port.
module vm_monitor
	import vm_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [NREG-1:0] low_cmp,
	input wire logic [NREG-1:0] high_cmp,
	input wire logic [NREG-1:0] reg_on,
	input wire logic [NREG-1:0] reg_ok,
	output vm_pkg::vm_limit_t [NREG-1:0] limit_pct,
	output logic [NREG-1:0] monitor_on,
	output logic [NREG-1:0] low_voltage_state,
	output logic [NREG-1:0] high_voltage_state,
	output logic irq
);
	import vm_pkg::*;

	localparam int TCW = $clog2(TICK_CYC + 1);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic addr_ok;
	logic rd_req;
	logic wr_ff;
	logic [7:0] waddr_ff;
	logic [31:0] rd_data;
	logic [1:0] low_filter_time_sel_ff;
	logic [1:0] high_filter_time_sel_ff;
	logic secure_write_en_ff;
	logic [5:0] switcher_low_limit_sel_ff;
	logic [1:0] linear_low_limit_sel_ff;
	logic [5:0] switcher_high_limit_sel_ff;
	logic [1:0] linear_high_limit_sel_ff;
	logic [7:0] event_ff;
	logic [7:0] event_mask_ff;
	logic [7:0] nxt_event;
	logic [NREG-1:0] mask_ff;
	logic [NREG-1:0] reg_on_d_ff;
	logic [NREG-1:0] active;
	logic [NREG-1:0] low_set;
	logic [NREG-1:0] high_set;
	logic [NREG-1:0] low_cmp_s;
	logic [NREG-1:0] high_cmp_s;
	logic [NREG-1:0] reg_on_s;
	logic [NREG-1:0] reg_ok_s;
	logic [TCW-1:0] tick_cnt_ff;
	logic tick_ff;
	logic [DB_CW-1:0] high_len;

	// ----------------------------------------
	// Per-regulator threshold code lookup
	// ----------------------------------------
	function automatic logic [1:0] low_sel(input int i);
		if (i == IDX_LINEAR_REG) begin
			low_sel = linear_low_limit_sel_ff;
		end else begin
			low_sel = switcher_low_limit_sel_ff[2*i +: 2];
		end
	endfunction

	function automatic logic [1:0] high_sel(input int i);
		if (i == IDX_LINEAR_REG) begin
			high_sel = linear_high_limit_sel_ff;
		end else begin
			high_sel = switcher_high_limit_sel_ff[2*i +: 2];
		end
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	vm_sync #(.W(4 * NREG)) u_sync (
		.clk(hclk),
		.rst_n(hresetn),
		.d({low_cmp, high_cmp, reg_on, reg_ok}),
		.q({low_cmp_s, high_cmp_s, reg_on_s, reg_ok_s})
	);

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	assign addr_ok = hsel && hready && htrans == HTRANS_NONSEQ;
	assign rd_req = addr_ok && !hwrite;

	// Zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Capture write address for the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ff <= 1'b0;
			waddr_ff <= 8'h00;
		end else begin
			wr_ff <= addr_ok && hwrite && haddr[31:8] == 24'h00_0000; // Unmapped writes dropped
			waddr_ff <= haddr[7:0];
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		rd_data = 32'h0000_0000;
		if (haddr[31:8] == 24'h00_0000) begin
			unique case (haddr[7:0])
				OFS_CFG: begin
					rd_data[CFG_LOW_LSB +: 2] = low_filter_time_sel_ff;
					rd_data[CFG_HIGH_LSB +: 2] = high_filter_time_sel_ff;
					rd_data[CFG_SECURE_BIT] = secure_write_en_ff;
				end
				OFS_LIMIT: begin
					rd_data[LIM_SW_LOW_LSB +: 6] = switcher_low_limit_sel_ff;
					rd_data[LIM_LIN_LOW_LSB +: 2] = linear_low_limit_sel_ff;
					rd_data[LIM_SW_HIGH_LSB +: 6] = switcher_high_limit_sel_ff;
					rd_data[LIM_LIN_HIGH_LSB +: 2] = linear_high_limit_sel_ff;
				end
				OFS_MON_ON, OFS_MON_ON_SECURE: begin
					rd_data[NREG-1:0] = monitor_on;
				end
				OFS_STATE: begin
					rd_data[NREG-1:0] = low_voltage_state;
					rd_data[ST_HIGH_LSB +: NREG] = high_voltage_state;
					rd_data[ST_MASK_LSB +: NREG] = mask_ff;
				end
				OFS_EVENT: begin
					rd_data[7:0] = event_ff;
				end
				OFS_EVENT_MASK: begin
					rd_data[7:0] = event_mask_ff;
				end
				default: begin
					rd_data = 32'h0000_0000;
				end
			endcase
		end
	end

	// Read data latched at the address phase for a zero-wait answer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_req) begin
			hrdata <= rd_data;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------

	// Debounce selects and secure mode
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_filter_time_sel_ff <= LOW_FILTER_RST; // [RL5]
			high_filter_time_sel_ff <= HIGH_FILTER_RST; // [RL7]
			secure_write_en_ff <= 1'b0;
		end else if (wr_ff && waddr_ff == OFS_CFG) begin
			low_filter_time_sel_ff <= hwdata[CFG_LOW_LSB +: 2];
			high_filter_time_sel_ff <= hwdata[CFG_HIGH_LSB +: 2];
			secure_write_en_ff <= hwdata[CFG_SECURE_BIT];
		end
	end

	// Threshold codes, switchers and linear regulator kept apart
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			switcher_low_limit_sel_ff <= SW_LIMIT_RST;
			linear_low_limit_sel_ff <= LIN_LIMIT_RST;
			switcher_high_limit_sel_ff <= SW_LIMIT_RST;
			linear_high_limit_sel_ff <= LIN_LIMIT_RST;
		end else if (wr_ff && waddr_ff == OFS_LIMIT) begin
			switcher_low_limit_sel_ff <= hwdata[LIM_SW_LOW_LSB +: 6];
			linear_low_limit_sel_ff <= hwdata[LIM_LIN_LOW_LSB +: 2];
			switcher_high_limit_sel_ff <= hwdata[LIM_SW_HIGH_LSB +: 6];
			linear_high_limit_sel_ff <= hwdata[LIM_LIN_HIGH_LSB +: 2];
		end
	end

	// Monitor enables; ordinary writes lose when secure mode is on
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			monitor_on <= MON_ON_RST; // [RL10]
		end else if (wr_ff && waddr_ff == OFS_MON_ON_SECURE) begin
			monitor_on <= hwdata[NREG-1:0]; // [RL11]
		end else if (wr_ff && waddr_ff == OFS_MON_ON && !secure_write_en_ff) begin
			monitor_on <= hwdata[NREG-1:0]; // [RL11]
		end
	end

	// Threshold percentages handed to the comparators
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			limit_pct <= '0;
		end else begin
			for (int i = 0; i < NREG; i++) begin
				limit_pct[i].low_pct <= 7'(LOW_PCT[low_sel(i)]); // [RL2]
				limit_pct[i].high_pct <= 7'(HIGH_PCT[high_sel(i)]); // [RL3]
			end
		end
	end

	// ----------------------------------------
	// Logic clock tick
	// ----------------------------------------

	// One tick per edge of the 100 kHz clock gives 5 us resolution
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_cnt_ff <= '0;
			tick_ff <= 1'b0;
		end else if (tick_cnt_ff == TCW'(TICK_CYC - 1)) begin
			tick_cnt_ff <= '0;
			tick_ff <= 1'b1; // [RL14]
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 1'b1;
			tick_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Start-up masking
	// ----------------------------------------

	// Rising enable masks until the regulator reports regulation
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reg_on_d_ff <= '0;
			mask_ff <= '0;
		end else begin
			reg_on_d_ff <= reg_on_s;
			for (int i = 0; i < NREG; i++) begin
				if (reg_on_s[i] && !reg_on_d_ff[i]) begin
					mask_ff[i] <= 1'b1; // [RL12]
				end else if (reg_ok_s[i] || !reg_on_s[i]) begin
					mask_ff[i] <= 1'b0; // [RL12]
				end
			end
		end
	end

	// Both monitors run only while enabled and unmasked
	assign active = monitor_on & ~mask_ff; // [RL8] [RL9] [RL12]

	// ----------------------------------------
	// Debounce filters
	// ----------------------------------------
	assign high_len = high_ticks(high_filter_time_sel_ff); // [RL6]

	for (genvar g = 0; g < NREG; g++) begin : g_reg
		// Low-side monitor, own filter per regulator
		vm_filter u_low (
			.clk(hclk),
			.rst_n(hresetn),
			.fault(low_cmp_s[g]),
			.enable(active[g]), // [RL1] [RL13]
			.tick(tick_ff),
			.limit(low_ticks(low_filter_time_sel_ff)), // [RL4]
			.state(low_voltage_state[g]), // [RL15] [RL16]
			.set_pulse(low_set[g])
		);

		// High-side monitor shares one debounce length
		vm_filter u_high (
			.clk(hclk),
			.rst_n(hresetn),
			.fault(high_cmp_s[g]),
			.enable(active[g]), // [RL1] [RL13]
			.tick(tick_ff),
			.limit(high_len),
			.state(high_voltage_state[g]), // [RL15] [RL16]
			.set_pulse(high_set[g])
		);
	end

	// ----------------------------------------
	// Events and interrupt
	// ----------------------------------------

	// Sticky events; a new event in a clearing read survives
	always_comb begin
		nxt_event = event_ff;
		if (rd_req && haddr == {24'h00_0000, OFS_EVENT}) begin
			nxt_event = 8'h00;
		end
		nxt_event = nxt_event | {high_set, low_set};
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			event_ff <= 8'h00;
		end else begin
			event_ff <= nxt_event;
		end
	end

	// Mask register, one enables the matching event
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			event_mask_ff <= EVENT_MASK_RST;
		end else if (wr_ff && waddr_ff == OFS_EVENT_MASK) begin
			event_mask_ff <= hwdata[7:0];
		end
	end

	// Level interrupt, registered one cycle behind the event bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(event_ff & event_mask_ff);
		end
	end

endmodule

// ---- hw/vm_pkg.sv ----
package vm_pkg;

	// ----------------------------------------
	// Regulators watched by the block
	// ----------------------------------------
	localparam int NREG = 4;
	localparam int IDX_SWITCHER_ONE = 0;
	localparam int IDX_SWITCHER_TWO = 1;
	localparam int IDX_SWITCHER_THREE = 2;
	localparam int IDX_LINEAR_REG = 3;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CFG = 8'h00;
	localparam logic [7:0] OFS_LIMIT = 8'h04;
	localparam logic [7:0] OFS_MON_ON = 8'h08;
	localparam logic [7:0] OFS_MON_ON_SECURE = 8'h0c;
	localparam logic [7:0] OFS_STATE = 8'h10;
	localparam logic [7:0] OFS_EVENT = 8'h14;
	localparam logic [7:0] OFS_EVENT_MASK = 8'h18;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CFG_LOW_LSB = 0;
	localparam int CFG_HIGH_LSB = 2;
	localparam int CFG_SECURE_BIT = 4;
	localparam int LIM_SW_LOW_LSB = 0;
	localparam int LIM_LIN_LOW_LSB = 6;
	localparam int LIM_SW_HIGH_LSB = 8;
	localparam int LIM_LIN_HIGH_LSB = 14;
	localparam int ST_HIGH_LSB = 4;
	localparam int ST_MASK_LSB = 8;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [1:0] LOW_FILTER_RST = 2'h2;
	localparam logic [1:0] HIGH_FILTER_RST = 2'h0;
	localparam logic [3:0] MON_ON_RST = 4'hf;
	localparam logic [5:0] SW_LIMIT_RST = 6'h00;
	localparam logic [1:0] LIN_LIMIT_RST = 2'h0;
	localparam logic [7:0] EVENT_MASK_RST = 8'h00;

	// ----------------------------------------
	// Timing: ticks on each edge of the 100 kHz logic clock
	// ----------------------------------------
	localparam int CLK_NS = 25;
	localparam int LF_CLK_KHZ = 100;
	localparam int TICK_NS = 1000000 / LF_CLK_KHZ / 2;
	localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam int LOW_DB_US [4] = '{5, 15, 30, 40};
	localparam int HIGH_DB_US [4] = '{30, 50, 80, 125};
	localparam int DB_CW = 5;

	// ----------------------------------------
	// Threshold tables, percent of nominal
	// ----------------------------------------
	localparam int LOW_PCT [4] = '{95, 93, 91, 89};
	localparam int HIGH_PCT [4] = '{105, 107, 109, 111};

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef struct packed {
		logic [6:0] high_pct;
		logic [6:0] low_pct;
	} vm_limit_t;

	// Debounce length in ticks for a time code
	function automatic logic [DB_CW-1:0] low_ticks(input logic [1:0] sel);
		low_ticks = DB_CW'(LOW_DB_US[sel] * 1000 / TICK_NS);
	endfunction

	function automatic logic [DB_CW-1:0] high_ticks(input logic [1:0] sel);
		high_ticks = DB_CW'(HIGH_DB_US[sel] * 1000 / TICK_NS);
	endfunction

endpackage

// ---- hw/vm_sync.sv ----
// Two-flop synchroniser for asynchronous levels
module vm_sync #(
	parameter int W = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;

	if (W < 1) begin : g_chk
		$error("vm_sync: width must be at least one");
	end

	// First stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			q <= '0;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule

// ---- hw/vm_filter.sv ----
// Debounce filter: fault must hold for limit ticks before state sets
module vm_filter
	import vm_pkg::*;
#(
	parameter int CW = DB_CW
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic fault,
	input wire logic enable,
	input wire logic tick,
	input wire logic [CW-1:0] limit,
	output logic state,
	output logic set_pulse
);
	logic [CW-1:0] cnt_ff;

	if (CW < DB_CW) begin : g_chk
		$error("vm_filter: counter too narrow for longest debounce");
	end

	// Any break in the fault restarts the count; a lowered limit cannot strand it above
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
		end else if (!enable || !fault) begin
			cnt_ff <= '0;
		end else if (tick && cnt_ff < limit) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	// Status follows the debounced fault, drops at once when clean
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= 1'b0;
			set_pulse <= 1'b0;
		end else begin
			set_pulse <= enable && fault && cnt_ff >= limit && !state;
			if (!enable || !fault) begin
				state <= 1'b0;
			end else if (cnt_ff >= limit) begin
				state <= 1'b1;
			end
		end
	end
endmodule

// ---- test/vm_monitor_sva.sv ----
module vm_monitor_sva (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [vm_pkg::NREG-1:0] low_cmp,
	input wire logic [vm_pkg::NREG-1:0] high_cmp,
	input wire logic [vm_pkg::NREG-1:0] reg_on,
	input wire logic [vm_pkg::NREG-1:0] reg_ok,
	input wire vm_pkg::vm_limit_t [vm_pkg::NREG-1:0] limit_pct,
	input wire logic [vm_pkg::NREG-1:0] monitor_on,
	input wire logic [vm_pkg::NREG-1:0] low_voltage_state,
	input wire logic [vm_pkg::NREG-1:0] high_voltage_state
);
	timeunit 1ns;
	timeprecision 1ps;
	import vm_pkg::*;
	logic [NREG-1:0] on_d_ff;
	logic [NREG-1:0] wait_ok_ff;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// Expected start-up mask at the pins: set by a rising enable, cleared by regulation or off
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			on_d_ff <= '0;
			wait_ok_ff <= '0;
		end else begin
			on_d_ff <= reg_on;
			for (int i = 0; i < NREG; i++) begin
				if (reg_on[i] && !on_d_ff[i]) begin
					wait_ok_ff[i] <= 1'b1;
				end else if (reg_ok[i] || !reg_on[i]) begin
					wait_ok_ff[i] <= 1'b0;
				end
			end
		end
	end
	// Zero wait states and OKAY once out of reset
	chk_bus_always_okay: assert property ($past(hresetn) |-> hreadyout && !hresp)
		else $error("bus slave not ready or not okay");
	for (genvar i = 0; i < NREG; i++) begin : g_reg
		// Thresholds only ever take table values
		chk_limit_in_table: assert property ($past(hresetn) |->
			limit_pct[i].low_pct inside {7'h5f, 7'h5d, 7'h5b, 7'h59} &&
			limit_pct[i].high_pct inside {7'h69, 7'h6b, 7'h6d, 7'h6f})
			else $error("threshold outside table");
		// Status rises only on a fault already held through the synchroniser
		chk_low_needs_fault: assert property ($rose(low_voltage_state[i]) |->
			$past(low_cmp[i], 3))
			else $error("low state rose without fault");
		// Shortest high filter is six ticks, so the fault is old
		chk_high_needs_fault: assert property ($rose(high_voltage_state[i]) |->
			$past(high_cmp[i], 3) && $past(high_cmp[i], 250))
			else $error("high state rose too early");
		chk_off_clears_state: assert property (!monitor_on[i] && !$past(monitor_on[i]) |->
			!low_voltage_state[i] && !high_voltage_state[i])
			else $error("state set on a disabled monitor");
		chk_low_clears: assert property (!low_cmp[i] [*6] |=> !low_voltage_state[i])
			else $error("low state held after fault cleared");
		chk_high_clears: assert property (!high_cmp[i] [*6] |=> !high_voltage_state[i])
			else $error("high state held after fault cleared");
		// No status may rise while a newly enabled regulator is still short of regulation;
		// the design sees the pins two flops late, so its mask trails this copy
		chk_mask_until_ok: assert property ($rose(low_voltage_state[i] | high_voltage_state[i]) |->
			!$past(wait_ok_ff[i], 3))
			else $error("status rose while masked");
	end
endmodule

bind vm_monitor vm_monitor_sva chk_u (
	.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
	.low_cmp(low_cmp), .high_cmp(high_cmp), .reg_on(reg_on), .reg_ok(reg_ok),
	.limit_pct(limit_pct), .monitor_on(monitor_on),
	.low_voltage_state(low_voltage_state), .high_voltage_state(high_voltage_state)
);

// ---- test/vm_analog_model.sv ----
module vm_analog_model (
	input wire vm_pkg::vm_limit_t [vm_pkg::NREG-1:0] limit_pct,
	input wire logic [vm_pkg::NREG-1:0] reg_on,
	input wire logic [vm_pkg::NREG-1:0][6:0] level,
	output logic [vm_pkg::NREG-1:0] low_cmp,
	output logic [vm_pkg::NREG-1:0] high_cmp
);
	timeunit 1ns;
	timeprecision 1ps;
	import vm_pkg::*;
	// Level is percent of nominal; an output switched off sits far below its limit
	always_comb begin
		for (int i = 0; i < NREG; i++) begin
			low_cmp[i] = !reg_on[i] || level[i] < limit_pct[i].low_pct;
			high_cmp[i] = reg_on[i] && level[i] > limit_pct[i].high_pct;
		end
	end
endmodule

// ---- test/vm_monitor_tb.sv ----
module vm_monitor_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import vm_pkg::*;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic hready, hreadyout, hresp, irq;
	logic [NREG-1:0] reg_on = 4'hf, reg_ok = 4'hf, low_cmp, high_cmp, monitor_on, lvs, hvs;
	logic [NREG-1:0][6:0] level = {4{7'h64}};
	vm_limit_t [NREG-1:0] limit_pct;
	int fail_count = 0, compares = 0, cyc = 0, t;
	int lus[4] = '{5, 15, 30, 40};
	int hus[4] = '{30, 50, 80, 125};
	assign hready = hreadyout;
	always #12.5 hclk = ~hclk;
	vm_monitor dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .low_cmp(low_cmp),
		.high_cmp(high_cmp), .reg_on(reg_on), .reg_ok(reg_ok), .limit_pct(limit_pct),
		.monitor_on(monitor_on), .low_voltage_state(lvs), .high_voltage_state(hvs), .irq(irq));
	vm_analog_model am_u (.limit_pct(limit_pct), .reg_on(reg_on), .level(level),
		.low_cmp(low_cmp), .high_cmp(high_cmp));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Cycle ceiling well above the roughly 21k cycles the tests need
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fail_count++;
			$display("MISMATCH %0t timeout", $time);
			test_done();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	// Single word transfer; waits on hready, read data taken at the data edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rd, exp, "register read");
	endtask
	task automatic wait_bit(input logic hi, input int idx, input int lim);
		t = 0;
		while ((hi ? hvs[idx] : lvs[idx]) !== 1'b1 && t < lim) begin
			@(posedge hclk);
			t++;
		end
	endtask
	// Fault on regulator c; tick is 5 us, so a code of us gives us/5 ticks
	task automatic deb(input logic hi, input int c, input int us);
		int n;
		n = us / 5;
		xfer(1'b1, OFS_CFG, hi ? 32'(c * 4 + 2) : 32'(c));
		if (hi && c == 0) begin
			level[c] <= 7'h78;
			repeat (800) @(posedge hclk);
			level[c] <= 7'h64;
			repeat (10) @(posedge hclk);
		end
		level[c] <= hi ? 7'h78 : 7'h50;
		wait_bit(hi, c, n * 200 + 20);
		chk(32'(t >= (n - 1) * 200 && t <= n * 200 + 10), 1, "filter time");
		repeat (3) @(negedge hclk);
		chk(irq, 32'(!hi && c < 2), "interrupt level");
		xfer(1'b0, OFS_EVENT, 32'h0);
		chk(rd, 32'h1 << (hi * 4 + c), "event bits");
		repeat (2) @(negedge hclk);
		chk(irq, 0, "interrupt after read");
		@(posedge hclk);
		level[c] <= 7'h64;
		repeat (8) @(negedge hclk);
		chk(hi ? hvs[c] : lvs[c], 0, "state after release");
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(negedge hclk);
		chk(monitor_on, 4'hf, "enables at reset");
		for (int i = 0; i < NREG; i++) begin
			chk(limit_pct[i], {7'h69, 7'h5f}, "limits at reset");
		end
		rchk(OFS_CFG, 32'h2);
		rchk(OFS_MON_ON, 32'hf);
		rchk(OFS_EVENT_MASK, 32'h0);
		rchk(8'h1c, 32'h0);
		xfer(1'b1, OFS_STATE, 32'hfff);
		rchk(OFS_STATE, 32'h0);
		$display("test reset done");
		for (int c = 0; c < 4; c++) begin
			xfer(1'b1, OFS_LIMIT, 32'(c * 16'h5555));
			repeat (2) @(negedge hclk);
			for (int i = 0; i < NREG; i++) begin
				chk(limit_pct[i], {7'(105 + 2 * c), 7'(95 - 2 * c)}, "limit code");
			end
		end
		xfer(1'b1, OFS_LIMIT, 32'h0);
		$display("test limits done");
		xfer(1'b1, OFS_CFG, 32'h12);
		xfer(1'b1, OFS_MON_ON, 32'h0);
		rchk(OFS_MON_ON, 32'hf);
		xfer(1'b1, OFS_MON_ON_SECURE, 32'h5);
		rchk(OFS_MON_ON, 32'h5);
		xfer(1'b1, OFS_MON_ON_SECURE, 32'hf);
		xfer(1'b1, OFS_CFG, 32'h2);
		xfer(1'b1, OFS_MON_ON, 32'h7);
		rchk(OFS_MON_ON, 32'h7);
		chk(monitor_on, 4'h7, "enables port");
		xfer(1'b1, OFS_MON_ON, 32'hf);
		$display("test secure done");
		xfer(1'b1, OFS_EVENT_MASK, 32'h3);
		for (int c = 0; c < 4; c++) begin
			deb(1'b0, c, lus[c]);
			deb(1'b1, c, hus[c]);
		end
		$display("test debounce done");
		xfer(1'b1, OFS_CFG, 32'h2);
		level[1] <= 7'h78;
		wait_bit(1'b1, 1, 1400);
		chk(hvs[1], 1, "enabled monitor");
		xfer(1'b1, OFS_MON_ON, 32'hd);
		repeat (3) @(negedge hclk);
		chk(hvs[1], 0, "state on disable");
		repeat (1500) @(negedge hclk);
		chk(hvs[1], 0, "disabled monitor");
		xfer(1'b1, OFS_MON_ON, 32'hf);
		wait_bit(1'b1, 1, 1400);
		chk(32'(t >= 990 && hvs[1] === 1'b1), 1, "restart after enable");
		level[1] <= 7'h64;
		$display("test disable done");
		xfer(1'b1, OFS_CFG, 32'h0);
		reg_on[0] <= 1'b0;
		reg_ok[0] <= 1'b0;
		level[0] <= 7'h50;
		repeat (400) @(posedge hclk);
		reg_on[0] <= 1'b1;
		repeat (600) @(posedge hclk);
		rchk(OFS_STATE, 32'h100);
		reg_ok[0] <= 1'b1;
		wait_bit(1'b0, 0, 420);
		chk(lvs[0], 1, "unmasked in regulation");
		$display("test mask done");
		test_done();
	end
endmodule
